//--- rtcc_pkg.sv
/*
 * rtcc_pkg: shared constants of the clock control and status block:
 * register offsets, field positions, reset values and widths.
 * Assumes a byte-addressed register port with 32-bit words.
 */

package rtcc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_SECONDS  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PRESC    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ALARM    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STAT     = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_LOCK     = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_WAKE_ON  = 8'h28;

    // ------------------------------------------------------------
    // clock_control_word fields
    // ------------------------------------------------------------
    localparam int CR_SWR  = 0;
    localparam int CR_WPE  = 1;
    localparam int CR_SUP  = 2;
    localparam int CR_UM   = 3;
    localparam int CR_WPS  = 4;
    localparam int CR_OSCILLATOR_ON = 8;
    localparam int CR_CLOCK_OUT_GATE = 9;
    localparam int CR_L16  = 10;
    localparam int CR_L8   = 11;
    localparam int CR_L4   = 12;
    localparam int CR_L2   = 13;
    localparam logic [DATA_W-1:0] CR_WR_MASK = 32'h0000_3f1f;
    localparam logic [DATA_W-1:0] CR_RESET   = 32'h0000_0000;

    // ------------------------------------------------------------
    // clock_status_word, lock word and interrupt fields
    // ------------------------------------------------------------
    localparam int SR_TIF = 0;
    localparam int SR_TOF = 1;
    localparam int SR_TAF = 2;
    localparam int SR_TCE = 4;
    localparam int LR_CRL = 4;
    localparam int LR_SRL = 5;
    localparam logic [DATA_W-1:0] LR_FIXED_ONES = 32'h0000_00cf;
    localparam int IRQ_W     = 3;
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_OVF   = 1;
    localparam int IRQ_INV   = 2;
    localparam int WAKE_ON_BIT = 0;

    // ------------------------------------------------------------
    // time counter widths
    // ------------------------------------------------------------
    localparam int PRESC_W = 15;
    localparam logic [PRESC_W-1:0] PRESC_LAST = 15'h7fff;
    localparam logic [DATA_W-1:0]  SEC_LAST   = 32'hffff_ffff;

endpackage

//--- rtcc_sync.sv
/*
 * rtcc_sync: two flip-flop synchroniser for one level.
 * Assumes the input may change at any time relative to mclk.
 */
`timescale 1ns/1ps

module rtcc_sync (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    typedef struct packed {
        logic ff1;
        logic ff2;
    } rtcc_sync_s;

    rtcc_sync_s st_reg;
    rtcc_sync_s st_next;

    // first stage feeds only the second stage
    always_comb begin
        st_next     = st_reg;
        st_next.ff1 = async_in;
        st_next.ff2 = st_reg.ff1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.ff2;
endmodule

//--- rtcc_ctrl.sv
/*
 * rtcc_ctrl: control and status logic of the real-time clock, with the
 * seconds, prescaler and alarm words, a lock word and interrupt status.
 * Assumes the oscillator output arrives on osc_clk_pin asynchronously and
 * much slower than mclk; registers are reached over a plain port.
 */
`timescale 1ns/1ps

module rtcc_ctrl (
    input  wire logic                         mclk,
    input  wire logic                         rst,
    input  wire logic [rtcc_pkg::ADDR_W-1:0]  bus_addr,
    input  wire logic [rtcc_pkg::DATA_W-1:0]  bus_wdata,
    input  wire logic                         bus_wr,
    input  wire logic                         bus_rd,
    input  wire logic                         bus_priv,
    output logic      [rtcc_pkg::DATA_W-1:0]  bus_rdata,
    output logic                              bus_err,
    input  wire logic                         osc_clk_pin,
    output logic                              load_2pf_enable,
    output logic                              load_4pf_enable,
    output logic                              load_8pf_enable,
    output logic                              load_16pf_enable,
    output logic                              oscillator_on,
    output logic                              periph_clk_enable,
    output logic                              wake_pin_out,
    output logic                              wake_pin_oe,
    output logic                              irq
);
    import rtcc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0]  seconds;
        logic [PRESC_W-1:0] presc;
        logic [DATA_W-1:0]  alarm;
        logic [DATA_W-1:0]  cr;
        logic               counter_run_enable;
        logic               alarm_flag;
        logic               overflow_flag;
        logic               invalid_time_flag;
        logic               status_lock_bit;
        logic               crl;
        logic [IRQ_W-1:0]   irq_st;
        logic [IRQ_W-1:0]   irq_mask;
        logic               wake_on;
        logic               osc_prev;
        logic [DATA_W-1:0]  rdata;
        logic               err;
        logic               wake_out;
        logic               wake_oe;
        logic               periph_en;
    } rtcc_state_s;

    // invalid flag set, both locks open and the 32 kHz clock passed after power-on reset; soft reset keeps the control lock
    localparam rtcc_state_s ST_RESET = '{
        cr: CR_RESET, invalid_time_flag: 1'b1, status_lock_bit: 1'b1, crl: 1'b1, periph_en: 1'b1, default: '0};

    rtcc_state_s st_reg;
    rtcc_state_s st_next;
    logic        osc_sync;
    logic        tick;
    logic        hide;
    logic        wr_ok;
    logic        run;
    logic        roll;
    logic        irq_lvl;
    logic        sr_open;

    // time words read as zero while the time is not trustworthy
    function automatic logic [DATA_W-1:0] time_view(input logic [DATA_W-1:0] v,
                                                    input logic              hz);
        return hz ? '0 : v;
    endfunction

    // ------------------------------------------------------------
    // oscillator edge detection
    // ------------------------------------------------------------
    rtcc_sync u_osc_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in (osc_clk_pin),
        .sync_out (osc_sync)
    );

    // an off oscillator yields no ticks even if the pin floats
    assign tick    = osc_sync & ~st_reg.osc_prev & st_reg.cr[CR_OSCILLATOR_ON];
    assign hide    = st_reg.overflow_flag | st_reg.invalid_time_flag;
    assign run     = tick & st_reg.counter_run_enable & ~hide & ~st_reg.cr[CR_SWR];
    assign roll    = run & (st_reg.presc == PRESC_LAST);
    assign wr_ok   = bus_wr & (bus_priv | st_reg.cr[CR_SUP]);
    assign irq_lvl = |(st_reg.irq_st & st_reg.irq_mask);
    // update mode only opens the lock while time is invalid, overflowed or stopped
    assign sr_open = st_reg.status_lock_bit | (st_reg.cr[CR_UM] &
                     (st_reg.invalid_time_flag | st_reg.overflow_flag | ~st_reg.counter_run_enable));

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic ev_alarm;
        logic ev_ovf;
        logic ev_inv;
        ev_alarm = 1'b0;
        ev_ovf   = 1'b0;
        ev_inv   = 1'b0;
        st_next  = st_reg;
        st_next.err   = 1'b0;
        st_next.rdata = '0;
        st_next.osc_prev = osc_sync;

        // soft reset holds all but itself and the power-on-only lock
        if (st_reg.cr[CR_SWR]) begin
            st_next             = ST_RESET;
            st_next.cr[CR_SWR]  = 1'b1;
            st_next.crl         = st_reg.crl;
            st_next.osc_prev    = osc_sync;
        end

        // time counting
        if (run) begin
            if (roll) begin
                st_next.presc   = '0;
                st_next.seconds = st_reg.seconds + 32'h0000_0001;
                ev_alarm        = (st_reg.alarm == st_reg.seconds);
                ev_ovf          = (st_reg.seconds == SEC_LAST);
            end else begin
                st_next.presc = st_reg.presc + 15'h0001;
            end
        end

        // register writes
        if (bus_wr && !wr_ok) begin
            st_next.err = 1'b1;
        end
        // during soft reset only the control word is writable, so the block can be released
        if (wr_ok && (!st_reg.cr[CR_SWR] || bus_addr == OFS_CTRL)) begin
            unique case (bus_addr)
                OFS_SECONDS: begin
                    if (!st_reg.counter_run_enable) begin
                        st_next.seconds = bus_wdata;
                        st_next.overflow_flag     = 1'b0;
                        st_next.invalid_time_flag     = 1'b0;
                    end
                end
                OFS_PRESC: begin
                    if (!st_reg.counter_run_enable) begin
                        st_next.presc = bus_wdata[PRESC_W-1:0];
                    end
                end
                OFS_ALARM: begin
                    st_next.alarm = bus_wdata;
                    st_next.alarm_flag   = 1'b0;
                end
                OFS_CTRL: begin
                    // bit 14 and reserved bits are never stored
                    if (st_reg.crl) begin
                        st_next.cr = bus_wdata & CR_WR_MASK;
                    end
                end
                OFS_STAT: begin
                    if (sr_open) begin
                        st_next.counter_run_enable = bus_wdata[SR_TCE];
                    end
                end
                OFS_LOCK: begin
                    // locks only close from software
                    st_next.crl = st_next.crl & bus_wdata[LR_CRL];
                    st_next.status_lock_bit = st_next.status_lock_bit & bus_wdata[LR_SRL];
                end
                OFS_IRQ_STAT: begin
                    st_next.irq_st = st_next.irq_st & ~bus_wdata[IRQ_W-1:0];
                end
                OFS_IRQ_MASK: begin
                    st_next.irq_mask = bus_wdata[IRQ_W-1:0];
                end
                OFS_WAKE_ON: begin
                    st_next.wake_on = bus_wdata[WAKE_ON_BIT];
                end
                default: begin
                end
            endcase
        end

        // hardware sets win over same-cycle clears
        if (ev_alarm) begin
            st_next.alarm_flag = 1'b1;
        end
        if (ev_ovf) begin
            st_next.overflow_flag = 1'b1;
        end
        ev_inv = st_next.invalid_time_flag & ~st_reg.invalid_time_flag;
        st_next.irq_st = st_next.irq_st | {ev_inv, ev_ovf, ev_alarm};

        // register reads, data stand one cycle later
        if (bus_rd) begin
            unique case (bus_addr)
                OFS_SECONDS:  st_next.rdata = time_view(st_reg.seconds, hide);
                OFS_PRESC:    st_next.rdata = time_view(32'(st_reg.presc), hide);
                OFS_ALARM:    st_next.rdata = st_reg.alarm;
                OFS_CTRL:     st_next.rdata = st_reg.cr & CR_WR_MASK;
                OFS_STAT: begin
                    // bit by bit, so no one-bit shift can lose its bit
                    st_next.rdata         = '0;
                    st_next.rdata[SR_TCE] = st_reg.counter_run_enable;
                    st_next.rdata[SR_TAF] = st_reg.alarm_flag;
                    st_next.rdata[SR_TOF] = st_reg.overflow_flag;
                    st_next.rdata[SR_TIF] = st_reg.invalid_time_flag;
                end
                OFS_LOCK: begin
                    st_next.rdata         = LR_FIXED_ONES;
                    st_next.rdata[LR_CRL] = st_reg.crl;
                    st_next.rdata[LR_SRL] = st_reg.status_lock_bit;
                end
                OFS_IRQ_STAT: st_next.rdata = 32'(st_reg.irq_st);
                OFS_IRQ_MASK: st_next.rdata = 32'(st_reg.irq_mask);
                OFS_WAKE_ON:  st_next.rdata = 32'(st_reg.wake_on);
                default:      st_next.rdata = '0;
            endcase
        end

        // wakeup pin: open-drain low on event, or a copy of the oscillator
        st_next.wake_out = 1'b0;
        st_next.wake_oe  = 1'b0;
        if (st_reg.cr[CR_WPE]) begin
            if (!st_reg.cr[CR_WPS]) begin
                st_next.wake_oe = irq_lvl | st_reg.wake_on;
            end else begin
                st_next.wake_oe  = st_reg.wake_on & ~st_reg.cr[CR_CLOCK_OUT_GATE];
                st_next.wake_out = osc_sync;
            end
        end
        st_next.periph_en = ~st_reg.cr[CR_CLOCK_OUT_GATE];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // oscillator trims come straight from the control word
    assign load_2pf_enable   = st_reg.cr[CR_L2];
    assign load_4pf_enable   = st_reg.cr[CR_L4];
    assign load_8pf_enable   = st_reg.cr[CR_L8];
    assign load_16pf_enable  = st_reg.cr[CR_L16];
    assign oscillator_on     = st_reg.cr[CR_OSCILLATOR_ON];
    assign periph_clk_enable = st_reg.periph_en;
    assign wake_pin_out      = st_reg.wake_out;
    assign wake_pin_oe       = st_reg.wake_oe;
    assign bus_rdata         = st_reg.rdata;
    assign bus_err           = st_reg.err;
    assign irq               = irq_lvl;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    load_caps_a: assert property (
        wr_ok && bus_addr == OFS_CTRL && st_reg.crl |=>
        load_2pf_enable == $past(bus_wdata[CR_L2]) &&
        load_16pf_enable == $past(bus_wdata[CR_L16]))
        else $error("load capacitor bits do not follow control write");

    clk_gate_a: assert property (
        st_reg.cr[CR_CLOCK_OUT_GATE] |=> !periph_clk_enable)
        else $error("peripheral clock passed while gated");

    osc_off_a: assert property (
        !oscillator_on |-> !tick)
        else $error("tick seen with oscillator off");

    wake_low_a: assert property (
        st_reg.cr[CR_WPE] && !st_reg.cr[CR_WPS] && (irq || st_reg.wake_on)
        |=> wake_pin_oe && !wake_pin_out)
        else $error("wakeup pin not pulled low");

    wake_idle_a: assert property (
        !st_reg.cr[CR_WPE] |=> !wake_pin_oe)
        else $error("wakeup pin driven while disabled");

    stat_lock_a: assert property (
        wr_ok && bus_addr == OFS_STAT && !st_reg.status_lock_bit && !st_reg.cr[CR_UM] &&
        !st_reg.cr[CR_SWR] |=> $stable(st_reg.counter_run_enable))
        else $error("locked status word accepted a write");

    priv_err_a: assert property (
        bus_wr && !bus_priv && !st_reg.cr[CR_SUP] |=> bus_err)
        else $error("unprivileged write without error pulse");

    err_pulse_a: assert property (
        !bus_wr || bus_priv || st_reg.cr[CR_SUP] |=> !bus_err)
        else $error("error pulse without a refused write");

    soft_reset_a: assert property (
        st_reg.cr[CR_SWR] && !(bus_wr && bus_addr == OFS_CTRL)
        |=> st_reg.invalid_time_flag && st_reg.cr[CR_SWR] && !st_reg.counter_run_enable)
        else $error("soft reset did not hold the block");

    ctrl_resv_a: assert property (
        bus_rd && bus_addr == OFS_CTRL |=>
        bus_rdata[31:14] == '0 && bus_rdata[7:5] == '0)
        else $error("reserved control bits read non-zero");

    time_hold_a: assert property (
        hide && !st_reg.cr[CR_SWR] &&
        !(bus_wr && (bus_addr == OFS_SECONDS || bus_addr == OFS_PRESC))
        |=> $stable(st_reg.seconds) && $stable(st_reg.presc))
        else $error("time advanced while invalid or overflowed");

    alarm_set_a: assert property (
        roll && st_reg.alarm == st_reg.seconds |=> st_reg.alarm_flag && st_reg.irq_st[IRQ_ALARM])
        else $error("alarm flag missed on match");

    flag_clear_a: assert property (
        wr_ok && bus_addr == OFS_SECONDS && !st_reg.counter_run_enable && !st_reg.cr[CR_SWR]
        |=> !st_reg.overflow_flag && !st_reg.invalid_time_flag)
        else $error("seconds write left time flags set");

    cov_alarm_c:    cover property (roll ##1 st_reg.alarm_flag);
    cov_priv_err_c: cover property (bus_err);
    cov_um_open_c:  cover property (wr_ok && bus_addr == OFS_STAT && !st_reg.status_lock_bit && sr_open);
endmodule

//--- rtcc_ctrl_tb_top.sv
/*
 * rtcc_ctrl_tb_top: self-checking bench for the clock control and status block.
 * Assumes rtcc_pkg is compiled first; the bench drives every port itself.
 */
`timescale 1ns/1ps

module rtcc_ctrl_tb_top;
    import rtcc_pkg::*;

    logic              mclk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] bus_addr = '0;
    logic [DATA_W-1:0] bus_wdata = '0;
    logic              bus_wr = 1'b0;
    logic              bus_rd = 1'b0;
    logic              bus_priv = 1'b1;
    logic              osc_clk_pin = 1'b0;
    logic [DATA_W-1:0] bus_rdata;
    logic              bus_err, irq, wake_pin_out, wake_pin_oe, oscillator_on;
    logic              load_2pf_enable, load_4pf_enable, load_8pf_enable, load_16pf_enable;
    logic              periph_clk_enable, rd_pend = 1'b0, wr_pend = 1'b0;
    logic [DATA_W-1:0] eq_rd[$];
    logic              eq_err[$];
    int                err_count = 0;
    int                n_compared = 0;
    int                cyc = 0;
    logic [DATA_W-1:0] r;

    rtcc_ctrl u_rtcc_ctrl (.mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_priv(bus_priv), .bus_rdata(bus_rdata),
        .bus_err(bus_err), .osc_clk_pin(osc_clk_pin), .load_2pf_enable(load_2pf_enable),
        .load_4pf_enable(load_4pf_enable), .load_8pf_enable(load_8pf_enable),
        .load_16pf_enable(load_16pf_enable), .oscillator_on(oscillator_on),
        .periph_clk_enable(periph_clk_enable), .wake_pin_out(wake_pin_out),
        .wake_pin_oe(wake_pin_oe), .irq(irq));

    // ------------------------------------------------------------
    // clock, timeout and reporting
    // ------------------------------------------------------------
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // ceiling is over twenty times the length of the whole sequence
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk32(string nm, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(string nm, logic e, logic g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // bus master tasks and result watcher
    // ------------------------------------------------------------
    // answers stand for one cycle, so the watcher looks exactly one edge after the strobe
    always @(posedge mclk) begin
        if (rd_pend) chk32("bus_rdata", eq_rd.pop_front(), bus_rdata);
        if (wr_pend) chk1("bus_err", eq_err.pop_front(), bus_err);
        rd_pend <= bus_rd;
        wr_pend <= bus_wr;
    end

    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic p = 1'b1,
                      logic e = 1'b0);
        @(posedge mclk);
        eq_err.push_back(e);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_priv  <= p;
        bus_wr    <= 1'b1;
        @(posedge mclk);
        bus_wr    <= 1'b0;
    endtask

    task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        @(posedge mclk);
        eq_rd.push_back(e);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge mclk);
        bus_rd   <= 1'b0;
    endtask

    // one slow oscillator period; the synchroniser needs a few mclk edges per level
    task automatic tick();
        @(posedge mclk) osc_clk_pin <= 1'b1;
        repeat (6) @(posedge mclk);
        osc_clk_pin <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(75029));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd(OFS_CTRL, 32'h0000_0000);
        rd(OFS_STAT, 32'h0000_0001);
        rd(OFS_SECONDS, 32'h0000_0000);
        rd(OFS_LOCK, 32'h0000_00ff);
        rd(8'h3c, 32'h0000_0000);
        // random control words with reserved bits forced high; bit 14 and reset kept low
        for (int i = 0; i < 6; i++) begin
            r = $urandom() & 32'h0000_3f1e;
            wr(OFS_CTRL, r | 32'hffff_80e0);
            rd(OFS_CTRL, r);
            repeat (3) @(posedge mclk);
            chk1("load_2pf", r[13], load_2pf_enable);
            chk1("load_4pf", r[12], load_4pf_enable);
            chk1("load_8pf", r[11], load_8pf_enable);
            chk1("load_16pf", r[10], load_16pf_enable);
            chk1("clk_pass", ~r[9], periph_clk_enable);
            chk1("osc_on", r[8], oscillator_on);
        end
        // privileged write gate: refused then accepted
        wr(OFS_CTRL, 32'h0000_0100);
        wr(OFS_CTRL, 32'h0000_0104, 1'b0, 1'b1);
        rd(OFS_CTRL, 32'h0000_0100);
        wr(OFS_CTRL, 32'h0000_0104);
        wr(OFS_CTRL, 32'h0000_0100, 1'b0, 1'b0);
        rd(OFS_CTRL, 32'h0000_0100);
        // time becomes valid, alarm on the next second
        wr(OFS_SECONDS, 32'h0000_0005);
        rd(OFS_STAT, 32'h0000_0000);
        rd(OFS_SECONDS, 32'h0000_0005);
        wr(OFS_PRESC, 32'h0000_7fff);
        wr(OFS_ALARM, 32'h0000_0005);
        wr(OFS_STAT, 32'hffff_ffff);
        rd(OFS_STAT, 32'h0000_0010);
        wr(OFS_SECONDS, 32'h0000_0009);
        tick();
        rd(OFS_SECONDS, 32'h0000_0006);
        rd(OFS_PRESC, 32'h0000_0000);
        rd(OFS_STAT, 32'h0000_0014);
        wr(OFS_ALARM, 32'h0000_0000);
        rd(OFS_STAT, 32'h0000_0010);
        // overflow of the seconds word, with its interrupt unmasked
        wr(OFS_STAT, 32'h0000_0000);
        wr(OFS_SECONDS, 32'hffff_ffff);
        wr(OFS_PRESC, 32'h0000_7fff);
        wr(OFS_STAT, 32'h0000_0010);
        wr(OFS_IRQ_MASK, 32'h0000_0002);
        tick();
        rd(OFS_STAT, 32'h0000_0012);
        rd(OFS_SECONDS, 32'h0000_0000);
        chk1("irq", 1'b1, irq);
        wr(OFS_IRQ_STAT, 32'h0000_0002);
        repeat (2) @(posedge mclk);
        chk1("irq", 1'b0, irq);
        wr(OFS_STAT, 32'h0000_0000);
        wr(OFS_SECONDS, 32'h0000_0003);
        rd(OFS_STAT, 32'h0000_0000);
        // wake pin in open-drain mode
        wr(OFS_WAKE_ON, 32'h0000_0001);
        wr(OFS_CTRL, 32'h0000_0102);
        repeat (3) @(posedge mclk);
        chk1("wake_oe", 1'b1, wake_pin_oe);
        chk1("wake_out", 1'b0, wake_pin_out);
        wr(OFS_CTRL, 32'h0000_0100);
        repeat (3) @(posedge mclk);
        chk1("wake_oe", 1'b0, wake_pin_oe);
        // wake pin as a copy of the oscillator, then blocked by the clock gate
        wr(OFS_CTRL, 32'h0000_0112);
        repeat (3) @(posedge mclk);
        chk1("wake_oe", 1'b1, wake_pin_oe);
        chk1("wake_out", 1'b0, wake_pin_out);
        osc_clk_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        chk1("wake_out", 1'b1, wake_pin_out);
        osc_clk_pin <= 1'b0;
        wr(OFS_CTRL, 32'h0000_0312);
        repeat (3) @(posedge mclk);
        chk1("wake_oe", 1'b0, wake_pin_oe);
        // software reset holds everything but its own bit and the control lock
        wr(OFS_CTRL, 32'h0000_0101);
        rd(OFS_CTRL, 32'h0000_0001);
        rd(OFS_STAT, 32'h0000_0001);
        wr(OFS_CTRL, 32'h0000_0000);
        rd(OFS_CTRL, 32'h0000_0000);
        // status lock, then the update-mode exception
        wr(OFS_LOCK, 32'h0000_0010);
        wr(OFS_STAT, 32'h0000_0010);
        rd(OFS_STAT, 32'h0000_0001);
        wr(OFS_CTRL, 32'h0000_0008);
        wr(OFS_STAT, 32'h0000_0010);
        rd(OFS_STAT, 32'h0000_0011);
        repeat (3) @(posedge mclk);
        conclude();
    end
endmodule
